// File: rtl/adcsc_defines.svh
// Offsets, field positions, reset values and widths for the converter start block
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
`define ADCSC_OFF_PERIOD 12'h000
`define ADCSC_OFF_CTRL 12'h004
`define ADCSC_OFF_TRIG 12'h008
`define ADCSC_OFF_STATUS 12'h00C
`define ADCSC_OFF_LASTREG 12'h010
`define ADCSC_PERIOD_RST 16'h0004
`define ADCSC_CTRL_ARM_BIT 0
`define ADCSC_CTRL_CLR_BIT 3
`define ADCSC_TRIG_GO_BIT 3
`define ADCSC_CTRL_REG_NUM 8'h00
`define ADCSC_CNT_W 16
`define ADCSC_NUM_CH 4
`endif

// File: rtl/adcsc_pkg.sv
// Types shared by the converter start block
package adcsc_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_NUMBER,
    SEQ_WAIT_CONTENTS,
    SEQ_COMPLETE
  } adcsc_seq_t;
  typedef struct packed {
    logic [7:0] number;
    logic [7:0] contents;
  } adcsc_wr_t;
endpackage : adcsc_pkg

// File: rtl/adcsc_top.sv
// Converter encode strobe, conversion-go flag and host control register loader
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "adcsc_defines.svh"
module adcsc_top (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic number_channel_arrived, // Channel three byte valid
  input wire logic [7:0] number_channel_data, // Channel three byte
  input wire logic contents_channel_arrived, // Channel four byte valid
  input wire logic [7:0] contents_channel_data, // Channel four byte
  input wire logic trigger_arrived, // Host trigger byte valid
  input wire logic [7:0] trigger_data, // Host trigger byte
  output logic adc_encode, // Converter encode strobe
  output logic [`ADCSC_NUM_CH-1:0] adc_convst // Per-channel conversion start
);

  // Reset release synchroniser. Assertion passes straight through so the
  // strobe and flags clear at once; release waits two edges so that no flop
  // leaves reset on a different edge from its neighbours.
  logic rst_meta_r; // First stage, read only by the second
  logic rst_sync_n_r; // Released reset copy
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // Block state. The loader keeps both bytes of the last host write so
  // software can see what the host last sent, whatever its number.
  logic [`ADCSC_CNT_W-1:0] period_r; // Encode half-period limit
  logic [`ADCSC_CNT_W-1:0] enc_cnt_r; // Encode counter
  logic [7:0] ctrl_r; // Converter control word
  logic go_r; // Conversion-go flag
  adcsc_pkg::adcsc_seq_t seq_r; // Loader state
  adcsc_pkg::adcsc_wr_t wr_r; // Latched number and contents
  logic ctrl_load; // Loader completes a control write
  logic apb_wr; // APB write access
  logic apb_ctrl_wr; // APB write to control word
  logic trig_set; // Trigger request from host or APB
  logic go_clr; // Clear request for the go flag

  // Bus decode. A write lands at the edge that ends the access phase, the
  // same edge at which the master sees pready, so no write is taken twice.
  assign apb_wr = psel && penable && pwrite;
  assign apb_ctrl_wr = apb_wr && (paddr == `ADCSC_OFF_CTRL);
  // Only register number zero reaches the control word; other numbers are
  // kept in the last-write snapshot for software to inspect.
  assign ctrl_load = (seq_r == adcsc_pkg::SEQ_COMPLETE) &&
                     (wr_r.number == `ADCSC_CTRL_REG_NUM);
  // A trigger byte from the host or its APB mirror. Both are one-cycle
  // strobes; a host byte and a software write in the same cycle simply
  // merge into one set request.
  assign trig_set = (trigger_arrived && trigger_data[`ADCSC_TRIG_GO_BIT]) ||
                    (apb_wr && (paddr == `ADCSC_OFF_TRIG) &&
                     pwdata[`ADCSC_TRIG_GO_BIT]);

  // Encode counter and strobe; counter compare is inclusive of the limit,
  // so each half period lasts limit plus one clocks. A limit lowered below
  // the running count is caught by the less-than test and ends the half
  // period at once instead of wrapping through the whole counter range.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      adc_encode <= 1'b0;
      enc_cnt_r <= '0;
    end else if (enc_cnt_r < period_r) begin
      enc_cnt_r <= enc_cnt_r + 1'b1;
    end else begin
      adc_encode <= ~adc_encode;
      enc_cnt_r <= '0;
    end
  end

  // Period limit written by software only. The running half period picks
  // up a new limit at once, so one half period of odd length may follow
  // a change; the strobe never stalls.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      period_r <= `ADCSC_PERIOD_RST;
    end else if (apb_wr && (paddr == `ADCSC_OFF_PERIOD)) begin
      period_r <= pwdata[`ADCSC_CNT_W-1:0];
    end
  end

  // Register loader: number on channel three, then contents on channel four.
  // Pulses that arrive out of turn are dropped on purpose: a stray contents
  // byte with no number before it has no register to go to. The extra
  // number state drops a contents byte sent in the cycle right after the number.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      seq_r <= adcsc_pkg::SEQ_IDLE;
      wr_r <= '0;
    end else begin
      unique case (seq_r)
        adcsc_pkg::SEQ_IDLE: begin
          if (number_channel_arrived) begin
            wr_r.number <= number_channel_data;
            seq_r <= adcsc_pkg::SEQ_NUMBER;
          end
        end
        adcsc_pkg::SEQ_NUMBER: begin
          seq_r <= adcsc_pkg::SEQ_WAIT_CONTENTS;
        end
        adcsc_pkg::SEQ_WAIT_CONTENTS: begin
          if (contents_channel_arrived) begin
            wr_r.contents <= contents_channel_data;
            seq_r <= adcsc_pkg::SEQ_COMPLETE;
          end
        end
        adcsc_pkg::SEQ_COMPLETE: begin
          seq_r <= adcsc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Control word: loader write wins over an APB write in the same cycle.
  // The host path cannot be retried from here, hence its priority; the
  // software write that loses is dropped, though its clear bit still reaches the go flag.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      ctrl_r <= '0;
    end else if (ctrl_load) begin
      ctrl_r <= wr_r.contents;
    end else if (apb_ctrl_wr) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Clear request from either writer of the control word; any write with
  // the clear bit high counts, whatever else the word holds
  assign go_clr = (ctrl_load && wr_r.contents[`ADCSC_CTRL_CLR_BIT]) ||
                  (apb_ctrl_wr && pwdata[`ADCSC_CTRL_CLR_BIT]);

  // Go flag; a set arriving with a clear wins so no trigger is lost.
  // The arm bit is looked at only when a trigger arrives, so dropping the
  // arm bit later leaves a running conversion alone until a clear comes.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin // Idle after reset
      go_r <= 1'b0;
    end else if (trig_set && ctrl_r[`ADCSC_CTRL_ARM_BIT]) begin
      go_r <= 1'b1;
    end else if (go_clr) begin
      go_r <= 1'b0;
    end
  end

  // All four channels start together from one flag. One flop per channel
  // keeps each start line a clean register output, so the four lines
  // leave the block with equal delay.
  genvar gi;
  generate
    for (gi = 0; gi < `ADCSC_NUM_CH; gi = gi + 1) begin : g_convst
      always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
          adc_convst[gi] <= 1'b0;
        end else begin
          adc_convst[gi] <= go_r;
        end
      end
    end
  endgenerate

  // APB slave: one access cycle always, read data registered in the setup
  // cycle. The read word is a snapshot taken at setup, so a flag that moves
  // during the access phase shows up on the next read.
  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          `ADCSC_OFF_PERIOD: prdata <= {16'h0000, period_r};
          `ADCSC_OFF_CTRL: prdata <= {24'h00_0000, ctrl_r};
          `ADCSC_OFF_TRIG: prdata <= 32'h0000_0000;
          `ADCSC_OFF_STATUS: prdata <= {27'h000_0000, adc_encode, go_r, 1'b0,
                                        seq_r};
          `ADCSC_OFF_LASTREG: prdata <= {16'h0000, wr_r};
          default: pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end

  // Checks on the encode counter and strobe. A count at or above the limit
  // must end the half period at the very next edge, even right after the
  // limit has been lowered below the running count.
  a_enc_toggle: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (enc_cnt_r >= period_r) |=> (adc_encode != $past(adc_encode)) && enc_cnt_r == '0)
    else $error("Encode strobe did not toggle at limit");
  a_enc_count: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (enc_cnt_r < period_r) |=> (enc_cnt_r == $past(enc_cnt_r) + 1'b1) &&
    $stable(adc_encode))
    else $error("Encode counter did not step by one");
  a_go_needs_arm: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    $rose(go_r) |-> $past(ctrl_r[`ADCSC_CTRL_ARM_BIT]))
    else $error("Go flag set without arm bit");
  a_go_trigger: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (trig_set && ctrl_r[`ADCSC_CTRL_ARM_BIT]) |=> go_r)
    else $error("Armed trigger did not set go flag");
  a_go_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (ctrl_load && wr_r.contents[`ADCSC_CTRL_CLR_BIT] && !trig_set) |=> !go_r)
    else $error("Clear bit did not clear go flag");
  a_convst_all: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    ##1 adc_convst == {`ADCSC_NUM_CH{$past(go_r)}})
    else $error("Converter starts not together with go flag");
  a_number_latch: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_IDLE && number_channel_arrived) |=>
    (wr_r.number == $past(number_channel_data)) ##1 seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS)
    else $error("Register number not latched");
  a_contents_done: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS && contents_channel_arrived) |=>
    seq_r == adcsc_pkg::SEQ_COMPLETE ##1 seq_r == adcsc_pkg::SEQ_IDLE)
    else $error("Contents write did not complete and return idle");
  a_reset_hold: assert property (@(posedge clk_sys)
    !rst_sync_n_r |-> !adc_encode && enc_cnt_r == '0)
    else $error("Encode not held clear in reset");

  // Start lines in reset; checked without a disable so that the held
  // state itself is covered, not only what follows the release.
  a_convst_reset: assert property (@(posedge clk_sys)
    !rst_sync_n_r |-> adc_convst == '0)
    else $error("Converter starts not held clear in reset");

  // Go flag bookkeeping. Between a set and a clear the flag must neither
  // drop nor rise by itself, or a conversion run would stop or start
  // without the host asking for it.
  a_go_stay_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (go_r && !go_clr) |=> go_r)
    else $error("Go flag dropped without a clear");

  a_go_stay_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (!go_r && !(trig_set && ctrl_r[`ADCSC_CTRL_ARM_BIT])) |=> !go_r)
    else $error("Go flag rose without an armed trigger");

  a_go_fall_cause: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    $fell(go_r) |-> $past(go_clr))
    else $error("Go flag fell without a clear request");

  a_go_apb_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (apb_ctrl_wr && pwdata[`ADCSC_CTRL_CLR_BIT] && !trig_set) |=> !go_r)
    else $error("Software clear bit did not clear go flag");

  // Register loader steps. Each state but the two waits lasts one cycle,
  // and the waits end only on their own channel's pulse.
  a_number_step: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_NUMBER) |=> (seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS))
    else $error("Loader did not move on to wait for contents");

  // A latched number must survive until the write completes
  a_number_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r != adcsc_pkg::SEQ_IDLE) |=> (wr_r.number == $past(wr_r.number)))
    else $error("Register number changed during a write");

  a_contents_wait: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS && !contents_channel_arrived) |=>
    (seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS))
    else $error("Loader left the contents wait without a pulse");

  a_contents_latch: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_WAIT_CONTENTS && contents_channel_arrived) |=>
    (wr_r.contents == $past(contents_channel_data)))
    else $error("Register contents not latched");

  // The control word takes exactly the byte the loader holds
  a_ctrl_loaded: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    ctrl_load |=> (ctrl_r == $past(wr_r.contents)))
    else $error("Control word not loaded from host contents");

  a_idle_wait: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_IDLE && !number_channel_arrived) |=>
    (seq_r == adcsc_pkg::SEQ_IDLE))
    else $error("Loader left idle without a number pulse");

  a_complete_once: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (seq_r == adcsc_pkg::SEQ_COMPLETE) |=> (seq_r == adcsc_pkg::SEQ_IDLE))
    else $error("Loader did not return to idle after a write");

endmodule : adcsc_top

// File: verification/adcsc_host_model.sv
// Host side model driving the number, contents and trigger byte channels
`timescale 1ns/10ps
module adcsc_host_model (
  input wire logic clk_sys, // System clock
  output logic number_channel_arrived, // Number byte valid
  output logic [7:0] number_channel_data, // Number byte
  output logic contents_channel_arrived, // Contents byte valid
  output logic [7:0] contents_channel_data, // Contents byte
  output logic trigger_arrived, // Trigger byte valid
  output logic [7:0] trigger_data // Trigger byte
);
  // Idle lines carry junk so a stale byte is never mistaken for data
  initial begin
    number_channel_arrived = 1'b0;
    contents_channel_arrived = 1'b0;
    trigger_arrived = 1'b0;
    number_channel_data = 8'h5A;
    contents_channel_data = 8'hA5;
    trigger_data = 8'hF7;
  end
  // One register write: number first, contents three cycles later
  task automatic send_reg(input logic [7:0] num, input logic [7:0] val);
    @(posedge clk_sys);
    number_channel_arrived <= 1'b1;
    number_channel_data <= num;
    @(posedge clk_sys);
    number_channel_arrived <= 1'b0;
    number_channel_data <= ~num;
    repeat (2) @(posedge clk_sys);
    contents_channel_arrived <= 1'b1;
    contents_channel_data <= val;
    @(posedge clk_sys);
    contents_channel_arrived <= 1'b0;
    contents_channel_data <= ~val;
    repeat (3) @(posedge clk_sys);
  endtask : send_reg
  // Trigger byte; caller arms first when it wants a start
  task automatic send_trig(input logic [7:0] b);
    @(posedge clk_sys);
    trigger_arrived <= 1'b1;
    trigger_data <= b;
    @(posedge clk_sys);
    trigger_arrived <= 1'b0;
    trigger_data <= ~b;
    repeat (3) @(posedge clk_sys);
  endtask : send_trig
endmodule : adcsc_host_model

// File: verification/adcsc_top_tb.sv
// Self-checking bench for the converter start block
`timescale 1ns/10ps
`include "adcsc_defines.svh"
module adcsc_top_tb;
  logic clk_sys = 1'b0; // System clock
  logic rstn = 1'b0; // Reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0000_0000; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready, pslverr; // APB answer
  logic n_v, c_v, t_v; // Host byte valids
  logic [7:0] n_d, c_d, t_d; // Host bytes
  logic adc_encode; // Encode strobe
  logic [`ADCSC_NUM_CH-1:0] adc_convst; // Start lines
  logic [31:0] q; // Last read word
  logic err; // Last error flag
  int miscompares = 0;
  int n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  adcsc_top uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .number_channel_arrived(n_v), .number_channel_data(n_d),
    .contents_channel_arrived(c_v), .contents_channel_data(c_d), .trigger_arrived(t_v),
    .trigger_data(t_d), .adc_encode(adc_encode), .adc_convst(adc_convst));
  adcsc_host_model host (.clk_sys(clk_sys), .number_channel_arrived(n_v),
    .number_channel_data(n_d), .contents_channel_arrived(c_v), .contents_channel_data(c_d),
    .trigger_arrived(t_v), .trigger_data(t_d));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reset state and an unmapped access
  task automatic t_reset;
    chk({31'h0, adc_encode}, 32'h0000_0000);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    apb(1'b0, `ADCSC_OFF_PERIOD, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask : t_reset
  // Half period of the strobe is limit plus one clocks
  task automatic t_encode;
    logic prev;
    int n;
    apb(1'b1, `ADCSC_OFF_PERIOD, 32'h0000_0002);
    for (int h = 0; h < 3; h++) begin
      prev = adc_encode;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (adc_encode === prev && n < 20);
      if (h > 0) chk(n, 32'h0000_0003);
    end
  endtask : t_encode
  // Trigger without arming, then arm, start and clear
  task automatic t_go;
    host.send_reg(8'h00, 8'h00);
    host.send_trig(8'h08);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    host.send_reg(8'h00, 8'h01);
    host.send_trig(8'hF7);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    host.send_trig(8'h08);
    chk({28'h0, adc_convst}, 32'h0000_000F);
    apb(1'b0, `ADCSC_OFF_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_000B, 32'h0000_0008);
    apb(1'b0, `ADCSC_OFF_LASTREG, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    host.send_reg(8'h00, 8'h09);
    chk({28'h0, adc_convst}, 32'h0000_0000);
  endtask : t_go
  // Software arm, trigger and clear, then a host write to another number
  task automatic t_apb;
    apb(1'b1, `ADCSC_OFF_CTRL, 32'h0000_0001);
    apb(1'b0, `ADCSC_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    apb(1'b1, `ADCSC_OFF_TRIG, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    apb(1'b1, `ADCSC_OFF_TRIG, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    chk({28'h0, adc_convst}, 32'h0000_000F);
    apb(1'b1, `ADCSC_OFF_CTRL, 32'h0000_0009);
    repeat (2) @(posedge clk_sys);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    host.send_reg(8'h05, 8'h3C);
    apb(1'b0, `ADCSC_OFF_LASTREG, 32'h0000_0000);
    chk(q, 32'h0000_053C);
    apb(1'b0, `ADCSC_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0009);
  endtask : t_apb
  // Reset in mid-run with the strobe high and go set: both clear at once
  task automatic t_rst_mid;
    host.send_trig(8'h08);
    chk({28'h0, adc_convst}, 32'h0000_000F);
    while (adc_encode !== 1'b0) @(posedge clk_sys);
    while (adc_encode !== 1'b1) @(posedge clk_sys);
    rstn <= 1'b0;
    @(negedge clk_sys);
    chk({31'h0, adc_encode}, 32'h0000_0000);
    chk({28'h0, adc_convst}, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, `ADCSC_OFF_PERIOD, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    apb(1'b0, `ADCSC_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask : t_rst_mid
  // Verdict and end of run
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog for a hung handshake
  initial begin
    #200us;
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_encode();
    t_go();
    t_apb();
    t_rst_mid();
    wrap_up();
  end
endmodule : adcsc_top_tb
